// *** logic/lane_ctrl_map.vh ***
// Purpose: Register map, field positions and fixed codes of lane_ctrl.
// Assumes: Included by its bare name from the design file.
// Notes:   Definitions only.
`ifndef LANE_CTRL_MAP_VH
`define LANE_CTRL_MAP_VH

`define REG_CTRL       8'h00
`define REG_SWING      8'h04
`define REG_EMPH       8'h08
`define REG_EQ         8'h0c
`define REG_STAT       8'h10

`define CTRL_MODE      2:0
`define CTRL_TXPOL     3
`define CTRL_RXSWAP    4
`define CTRL_LOCKREF   5
`define CTRL_INT4      6
`define CTRL_FAB       8:7
`define CTRL_RST       9'h082

`define STAT_OVF       4
`define STAT_UNF       5

`define MODE_X10       3'h0
`define MODE_X16       3'h1
`define MODE_X20       3'h2
`define MODE_X32       3'h3
`define MODE_X40       3'h4
`define MULT_10        6'h0a
`define MULT_16        6'h10
`define MULT_20        6'h14
`define MULT_32        6'h20
`define MULT_40        6'h28

`define FAB_1B         2'h0
`define FAB_2B         2'h1
`define FAB_4B         2'h2
`define FAB_8B         2'h3
`define RATIO_1_2      2'h0
`define RATIO_1_1      2'h1
`define RATIO_2_1      2'h2
`define RATIO_NONE     2'h3

`define ST_REF         2'h0
`define ST_ACQ         2'h1
`define ST_DATA        2'h2

`define LOCK_EDGES_DEF 5000
`define MISS_LIMIT_DEF 75
`define EMPH_MAX       4'ha
`define FIFO_DEPTH_DEF 4

`define RESP_OK        2'h0
`define RESP_SLVERR    2'h2

`endif

// *** logic/lane_ctrl.v ***
// Purpose: Control and clocking side of one serial transceiver lane.
// Assumes: One clock; bit_tick marks serial bit times from the lane PLL.
// Notes:   Registers over AXI4-Lite; all state frozen while ce is low.
//
// Overview of operation
// - Bit clock multiplier is 10, 16, 20, 32 or 40 by mode.
// - Transmit polarity input swaps the differential serial outputs.
// - Recovered clock is bit rate divided by 10, 16, 20, 32 or 40.
// - Data lock survives up to 75 missing transitions, then is lost.
// - Default: track data when present, else lock to reference.
// - Lock-source override forces reference lock and ignores data phase.
// - Configuration option exchanges the two receive inputs.
// - Internal coding width is two bytes or four bytes.
// - Two-byte internal width allows fabric ports of 1, 2 or 4 bytes.
// - Four-byte internal width allows fabric ports of 4 or 8 bytes.
// - Fabric side and internal side run on their own user clocks; here both sides run on mclk.
// - Transmit data enters a FIFO acting as phase-only pass-through.
// - Swing and emphasis load at reset, changeable at run time.
// - Emphasis steps span 0 to 500 percent pre-emphasis.
// - Receive equalization set by configuration or by bus writes.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "lane_ctrl_map.vh"

module lane_ctrl #(
    parameter        [12:0] LOCK_EDGES = `LOCK_EDGES_DEF,
    parameter        [6:0]  MISS_LIMIT = `MISS_LIMIT_DEF,
    parameter               DATA_W     = 16,
    parameter               PTR_W      = 2,
    parameter               FIFO_DEPTH = `FIFO_DEPTH_DEF,
    parameter        [3:0]  SWING_INIT = 4'h8,
    parameter        [3:0]  EMPH_INIT  = 4'h2,
    parameter        [2:0]  EQ_INIT    = 3'h0
) (
    // Clock, reset, enable
    input  wire              mclk,
    input  wire              srst,
    input  wire              ce,
    // AXI4-Lite write
    input  wire [7:0]        awaddr,
    input  wire              awvalid,
    output reg               awready,
    input  wire [31:0]       wdata,
    input  wire [3:0]        wstrb,
    input  wire              wvalid,
    output reg               wready,
    output reg  [1:0]        bresp,
    output reg               bvalid,
    input  wire              bready,
    // AXI4-Lite read
    input  wire [7:0]        araddr,
    input  wire              arvalid,
    output reg               arready,
    output reg  [31:0]       rdata,
    output reg  [1:0]        rresp,
    output reg               rvalid,
    input  wire              rready,
    // Serial lane pins
    input  wire              serial_in_pos,
    input  wire              serial_in_neg,
    output reg               serial_out_pos,
    output reg               serial_out_neg,
    // Lane PLL and serializer side
    input  wire              bit_tick,
    input  wire              tx_serial_bit,
    output reg  [5:0]        pll_multiplier,
    output reg               rx_recovered_clock,
    output reg               rx_data_bit,
    // User logic controls
    input  wire              tx_polarity_invert,
    input  wire              rx_lock_source_select,
    // Transmit FIFO
    input  wire              tx_wr,
    input  wire [DATA_W-1:0] tx_din,
    input  wire              tx_rd,
    output reg  [DATA_W-1:0] tx_dout,
    output reg               tx_dout_valid,
    // Status and analog settings
    output reg               rx_locked,
    output reg               rx_on_reference,
    output reg  [1:0]        user_clock_ratio,
    output reg               width_error,
    output reg  [3:0]        swing_level,
    output reg  [3:0]        emphasis_level,
    output reg  [2:0]        rx_equalization_level
);

    localparam [PTR_W:0] DEPTH_C = FIFO_DEPTH;

    function [5:0] mult_of;
        input [2:0] mode;
        begin
            case (mode)
                `MODE_X10: mult_of = `MULT_10;
                `MODE_X16: mult_of = `MULT_16;
                `MODE_X20: mult_of = `MULT_20;
                `MODE_X32: mult_of = `MULT_32;
                default:   mult_of = `MULT_40;
            endcase
        end
    endfunction

    function [1:0] ratio_of;
        input       int4;
        input [1:0] fab;
        begin
            case ({int4, fab})
                {1'b0, `FAB_1B}: ratio_of = `RATIO_1_2;
                {1'b0, `FAB_2B}: ratio_of = `RATIO_1_1;
                {1'b0, `FAB_4B}: ratio_of = `RATIO_2_1;
                {1'b1, `FAB_4B}: ratio_of = `RATIO_1_1;
                {1'b1, `FAB_8B}: ratio_of = `RATIO_2_1;
                default:         ratio_of = `RATIO_NONE;
            endcase
        end
    endfunction

    function [7:0] merge8;
        input [7:0] old;
        input [7:0] upd;
        input       en;
        begin
            merge8 = en ? upd : old;
        end
    endfunction

    reg [8:0]        ctrl_ff;
    reg              aw_got_ff;
    reg              w_got_ff;
    reg [7:0]        waddr_ff;
    reg [31:0]       wdata_ff;
    reg [3:0]        wstrb_ff;
    reg              ovf_ff;
    reg              unf_ff;
    reg              pos_s1_ff, pos_s2_ff, pos_s3_ff, pos_f_ff;
    reg              neg_s1_ff, neg_s2_ff, neg_s3_ff, neg_f_ff;
    reg              prev_bit_ff;
    reg [1:0]        state_ff;
    reg [12:0]       edge_cnt_ff;
    reg [6:0]        miss_cnt_ff;
    reg [5:0]        div_cnt_ff;
    reg [DATA_W-1:0] fifo_mem [0:FIFO_DEPTH-1];
    reg [PTR_W-1:0]  wr_ptr_ff;
    reg [PTR_W-1:0]  rd_ptr_ff;
    reg [PTR_W:0]    count_ff;

    wire       force_ref = rx_lock_source_select | ctrl_ff[`CTRL_LOCKREF];
    // Swapped pins read the negative leg as the data sense.
    wire       rx_bit    = ctrl_ff[`CTRL_RXSWAP] ? neg_f_ff : pos_f_ff;
    wire       trans     = bit_tick & (rx_bit != prev_bit_ff);
    wire       miss_over = miss_cnt_ff > MISS_LIMIT;
    wire [5:0] mult      = mult_of(ctrl_ff[`CTRL_MODE]);
    wire [4:0] half      = mult[5:1];
    wire [1:0] ratio     = ratio_of(ctrl_ff[`CTRL_INT4], ctrl_ff[`CTRL_FAB]);
    wire       mode_bad  = ctrl_ff[`CTRL_MODE] > `MODE_X40;
    wire       full      = count_ff == DEPTH_C;
    wire       empty     = count_ff == {(PTR_W+1){1'b0}};
    wire       do_wr     = tx_wr & ~full;
    wire       do_rd     = tx_rd & ~empty;
    wire       wr_go     = aw_got_ff & w_got_ff & ~bvalid;
    wire       aw_take   = awvalid & awready;
    wire       w_take    = wvalid & wready;
    wire       ar_take   = arvalid & arready;
    wire       clr_ovf   = wr_go & (waddr_ff == `REG_STAT)
                           & wstrb_ff[0] & wdata_ff[`STAT_OVF];
    wire       clr_unf   = wr_go & (waddr_ff == `REG_STAT)
                           & wstrb_ff[0] & wdata_ff[`STAT_UNF];

    reg [31:0] rd_word;
    reg        rd_bad;

    always @*
    begin
        rd_word = 32'h0;
        rd_bad  = 1'b0;
        case (araddr)
            `REG_CTRL:  rd_word[8:0] = ctrl_ff;
            `REG_SWING: rd_word[3:0] = swing_level;
            `REG_EMPH:  rd_word[3:0] = emphasis_level;
            `REG_EQ:    rd_word[2:0] = rx_equalization_level;
            `REG_STAT:  rd_word[21:0] = {mult, ratio, unf_ff, ovf_ff,
                                         width_error, state_ff,
                                         rx_on_reference, rx_locked,
                                         7'h0};
            default:    rd_bad = 1'b1;
        endcase
    end

    // Bus handshakes: each ready is a one-cycle pulse offered to a
    // waiting valid, so a held valid is taken exactly once.
    always @(posedge mclk)
    begin
        if (srst)
        begin
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            waddr_ff  <= 8'h0;
            wdata_ff  <= 32'h0;
            wstrb_ff  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OK;
            arready   <= 1'b0;
            rvalid    <= 1'b0;
            rdata     <= 32'h0;
            rresp     <= `RESP_OK;
        end
        else if (ce)
        begin
            awready <= awvalid & ~awready & ~aw_got_ff & ~bvalid;
            wready  <= wvalid & ~wready & ~w_got_ff & ~bvalid;
            arready <= arvalid & ~arready & ~rvalid;
            if (aw_take)
            begin
                aw_got_ff <= 1'b1;
                waddr_ff  <= awaddr;
            end
            if (w_take)
            begin
                w_got_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (wr_go)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (waddr_ff > `REG_STAT) ? `RESP_SLVERR
                                                    : `RESP_OK;
            end
            else if (bvalid & bready)
                bvalid <= 1'b0;
            if (ar_take)
            begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= rd_bad ? `RESP_SLVERR : `RESP_OK;
            end
            else if (rvalid & rready)
                rvalid <= 1'b0;
        end
    end

    // Settings start from the configured values and stay writable.
    always @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_ff               <= `CTRL_RST;
            swing_level           <= SWING_INIT;
            emphasis_level        <= EMPH_INIT;
            rx_equalization_level <= EQ_INIT;
        end
        else if (ce & wr_go)
        begin
            case (waddr_ff)
                `REG_CTRL:
                begin
                    ctrl_ff[7:0] <= merge8(ctrl_ff[7:0], wdata_ff[7:0],
                                           wstrb_ff[0]);
                    if (wstrb_ff[1])
                        ctrl_ff[8] <= wdata_ff[8];
                end
                `REG_SWING:
                    if (wstrb_ff[0])
                        swing_level <= wdata_ff[3:0];
                `REG_EMPH:
                    if (wstrb_ff[0])
                        emphasis_level <= (wdata_ff[3:0] > `EMPH_MAX)
                                          ? `EMPH_MAX
                                          : wdata_ff[3:0];
                `REG_EQ:
                    if (wstrb_ff[0])
                        rx_equalization_level <= wdata_ff[2:0];
                default:
                    ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // Pins cross in through three stages; a level is accepted only
    // when the second and third stages agree.
    always @(posedge mclk)
    begin
        if (srst)
        begin
            {pos_s1_ff, pos_s2_ff, pos_s3_ff, pos_f_ff} <= 4'h0;
            {neg_s1_ff, neg_s2_ff, neg_s3_ff, neg_f_ff} <= 4'hf;
        end
        else if (ce)
        begin
            pos_s1_ff <= serial_in_pos;
            pos_s2_ff <= pos_s1_ff;
            pos_s3_ff <= pos_s2_ff;
            neg_s1_ff <= serial_in_neg;
            neg_s2_ff <= neg_s1_ff;
            neg_s3_ff <= neg_s2_ff;
            if (pos_s2_ff == pos_s3_ff)
                pos_f_ff <= pos_s3_ff;
            if (neg_s2_ff == neg_s3_ff)
                neg_f_ff <= neg_s3_ff;
        end
    end

    // Lock tracking over serial bit times.
    always @(posedge mclk)
    begin
        if (srst)
        begin
            state_ff    <= `ST_REF;
            edge_cnt_ff <= 13'h0;
            miss_cnt_ff <= 7'h0;
            prev_bit_ff <= 1'b0;
            rx_data_bit <= 1'b0;
        end
        else if (ce)
        begin
            if (bit_tick)
            begin
                prev_bit_ff <= rx_bit;
                rx_data_bit <= rx_bit;
                if (trans)
                    miss_cnt_ff <= 7'h0;
                else if (~miss_over)
                    miss_cnt_ff <= miss_cnt_ff + 7'h1;
            end
            case (state_ff)
                `ST_REF:
                    if (~force_ref & trans)
                    begin
                        state_ff    <= `ST_ACQ;
                        edge_cnt_ff <= 13'h1;
                    end
                `ST_ACQ:
                    if (force_ref | miss_over)
                        state_ff <= `ST_REF;
                    else if (edge_cnt_ff >= LOCK_EDGES)
                        state_ff <= `ST_DATA;
                    else if (trans)
                        edge_cnt_ff <= edge_cnt_ff + 13'h1;
                `ST_DATA:
                    if (force_ref | miss_over)
                        state_ff <= `ST_REF;
                default:
                    state_ff <= `ST_REF;
            endcase
        end
    end

    // Recovered clock divider; it re-phases to data edges only while
    // locked to data, so reference lock ignores incoming phase.
    always @(posedge mclk)
    begin
        if (srst)
        begin
            div_cnt_ff         <= 6'h0;
            rx_recovered_clock <= 1'b0;
        end
        else if (ce & bit_tick)
        begin
            if (trans & (state_ff == `ST_DATA))
                div_cnt_ff <= 6'h0;
            else if (div_cnt_ff >= {1'b0, half - 5'h1})
            begin
                div_cnt_ff         <= 6'h0;
                rx_recovered_clock <= ~rx_recovered_clock;
            end
            else
                div_cnt_ff <= div_cnt_ff + 6'h1;
        end
    end

    // Transmit FIFO: fabric writes, coding side reads; a frequency
    // locked pair keeps it near empty so it only absorbs phase.
    always @(posedge mclk)
    begin
        if (srst)
        begin
            wr_ptr_ff     <= {PTR_W{1'b0}};
            rd_ptr_ff     <= {PTR_W{1'b0}};
            count_ff      <= {(PTR_W+1){1'b0}};
            tx_dout       <= {DATA_W{1'b0}};
            tx_dout_valid <= 1'b0;
            ovf_ff        <= 1'b0;
            unf_ff        <= 1'b0;
        end
        else if (ce)
        begin
            if (do_wr)
            begin
                fifo_mem[wr_ptr_ff] <= tx_din;
                wr_ptr_ff           <= wr_ptr_ff + 1'b1;
            end
            if (do_rd)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            tx_dout_valid <= do_rd;
            if (do_rd)
                tx_dout <= fifo_mem[rd_ptr_ff];
            if (do_wr & ~do_rd)
                count_ff <= count_ff + 1'b1;
            else if (do_rd & ~do_wr)
                count_ff <= count_ff - 1'b1;
            // A new fault in the clearing cycle keeps the flag set.
            ovf_ff <= (tx_wr & full) | (ovf_ff & ~clr_ovf);
            unf_ff <= (tx_rd & empty) | (unf_ff & ~clr_unf);
        end
    end

    // Lane outputs and decoded configuration.
    always @(posedge mclk)
    begin
        if (srst)
        begin
            serial_out_pos   <= 1'b0;
            serial_out_neg   <= 1'b1;
            pll_multiplier   <= `MULT_20;
            rx_locked        <= 1'b0;
            rx_on_reference  <= 1'b1;
            user_clock_ratio <= `RATIO_1_1;
            width_error      <= 1'b0;
        end
        else if (ce)
        begin
            serial_out_pos   <= tx_serial_bit ^ tx_polarity_invert
                                ^ ctrl_ff[`CTRL_TXPOL];
            serial_out_neg   <= ~(tx_serial_bit ^ tx_polarity_invert
                                ^ ctrl_ff[`CTRL_TXPOL]);
            pll_multiplier   <= mult;
            rx_locked        <= state_ff == `ST_DATA;
            rx_on_reference  <= state_ff != `ST_DATA;
            user_clock_ratio <= ratio;
            width_error      <= mode_bad
                                | (ratio == `RATIO_NONE);
        end
    end

endmodule // lane_ctrl

// *** tb/lane_ctrl_asserts.sv ***
// Purpose: Port-level checks on lane_ctrl.
// Assumes: One clock; srst synchronous, active high.
// Notes:   Bound from the bench top file.
`timescale 1ns/10ps
module lane_ctrl_asserts (
    // Clock and reset
    input  wire       mclk,
    input  wire       srst,
    // Register bus
    input  wire       awvalid,
    input  wire       awready,
    input  wire       wvalid,
    input  wire       wready,
    input  wire       bvalid,
    input  wire       bready,
    input  wire [1:0] bresp,
    input  wire       arvalid,
    input  wire       arready,
    input  wire       rvalid,
    // Lane
    input  wire       tx_serial_bit,
    input  wire       tx_polarity_invert,
    input  wire       serial_out_pos,
    input  wire       serial_out_neg,
    input  wire [5:0] pll_multiplier,
    input  wire       rx_lock_source_select,
    input  wire       rx_locked,
    input  wire       rx_on_reference,
    input  wire [1:0] user_clock_ratio,
    input  wire       width_error,
    input  wire [3:0] emphasis_level
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence force_held;
        rx_lock_source_select [*2];
    endsequence
    write_resp_a: assert property (wr_taken |-> ##[1:2] bvalid)
        else $error("write response late");
    read_resp_a: assert property (arvalid && arready |=> rvalid)
        else $error("read response late");
    resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    no_accept_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    diff_pair_a: assert property (serial_out_neg == !serial_out_pos)
        else $error("serial legs not complementary");
    tx_invert_a: assert property (!$past(srst) && $changed(tx_polarity_invert)
        && $stable(tx_serial_bit) |=> $changed(serial_out_pos))
        else $error("polarity change did not flip output");
    mult_legal_a: assert property (pll_multiplier inside
        {6'h0a, 6'h10, 6'h14, 6'h20, 6'h28})
        else $error("illegal multiplier");
    force_ref_a: assert property (force_held |=> rx_on_reference && !rx_locked)
        else $error("forced reference lock ignored");
    lock_pair_a: assert property (rx_on_reference != rx_locked)
        else $error("lock source outputs disagree");
    ratio_err_a: assert property (user_clock_ratio == 2'h3 |-> width_error)
        else $error("invalid width without error");
    emph_max_a: assert property (emphasis_level <= 4'ha)
        else $error("emphasis above top step");
endmodule // lane_ctrl_asserts

// *** tb/remote_lane.sv ***
// Purpose: Remote transmitter driving the receive lane pins.
// Assumes: bit_tick marks serial bit times in the mclk domain.
// Notes:   Idle means no transitions; the lane keeps its last level.
`timescale 1ns/10ps
module remote_lane (
    // Clock and bit timing
    input  wire mclk,
    input  wire bit_tick,
    input  wire send_en,
    // Differential lane
    output reg  serial_in_pos,
    output reg  serial_in_neg
);
    initial
    begin
        serial_in_pos = 1'b0;
        serial_in_neg = 1'b1;
    end
    // Alternating bits give the densest transition stream for lock.
    always @(posedge mclk)
        if (bit_tick && send_en)
        begin
            serial_in_pos <= !serial_in_pos;
            serial_in_neg <= serial_in_pos;
        end
endmodule // remote_lane

// *** tb/lane_ctrl_bench.sv ***
// Purpose: Self-checking bench for lane_ctrl.
// Assumes: Short lock and miss counts set by parameters.
// Notes:   One bit time is two mclk cycles.
`timescale 1ns/10ps
module lane_ctrl_bench;
    localparam LOCK_EDGES = 8;
    localparam MISS_LIMIT = 4;
    logic        mclk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic        bit_tick, tx_serial_bit, tx_polarity_invert;
    logic        rx_lock_source_select, tx_wr, tx_rd, send_en;
    logic [15:0] tx_din;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         serial_in_pos, serial_in_neg, serial_out_pos;
    wire         serial_out_neg, rx_recovered_clock, rx_data_bit;
    wire         tx_dout_valid, rx_locked, rx_on_reference, width_error;
    wire [1:0]   bresp, rresp, user_clock_ratio;
    wire [31:0]  rdata;
    wire [5:0]   pll_multiplier;
    wire [15:0]  tx_dout;
    wire [3:0]   swing_level, emphasis_level;
    wire [2:0]   rx_equalization_level;
    int          checks, miscompares, cycles;
    logic [31:0] rst_tab [4] = '{32'h82, 32'h8, 32'h2, 32'h0};
    logic [5:0]  mult_tab [5] = '{6'h0a, 6'h10, 6'h14, 6'h20, 6'h28};
    logic [1:0]  ratio_tab [8] = '{2'h0, 2'h1, 2'h2, 2'h3,
                                   2'h3, 2'h3, 2'h1, 2'h2};

    lane_ctrl #(.LOCK_EDGES(LOCK_EDGES), .MISS_LIMIT(MISS_LIMIT))
        i_lane_ctrl (.ce(1'b1), .wstrb(4'hf), .*);
    remote_lane i_remote_lane (.*);

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        bit_tick <= ~bit_tick;
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            miscompares++;
            end_of_test;
        end
    end

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rise;
        while (rx_recovered_clock !== 1'b0) @(posedge mclk);
        while (rx_recovered_clock !== 1'b1) @(posedge mclk);
    endtask
    task automatic wait_lock(input logic v, output int n);
        n = 0;
        while (rx_locked !== v && n < 300)
        begin
            @(posedge mclk);
            n++;
        end
        chk(rx_locked, v);
    endtask

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++)
        begin
            rd(8'(4 * i), d, r);
            chk(d, rst_tab[i]);
        end
        chk(pll_multiplier, 6'h14);
        chk(user_clock_ratio, 2'h1);
    endtask
    task automatic t_modes;
        logic [1:0] r;
        time        t0;
        for (int m = 0; m < 5; m++)
        begin
            wr(8'h00, 32'h080 | 32'(m), r);
            repeat (3) @(posedge mclk);
            chk(pll_multiplier, mult_tab[m]);
            rise();
            rise();
            t0 = $time;
            rise();
            chk(32'(($time - t0) / 20), mult_tab[m]);
        end
        wr(8'h00, 32'h087, r);
        repeat (3) @(posedge mclk);
        chk(width_error, 1'b1);
    endtask
    task automatic t_widths;
        logic [1:0] r;
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h00, {23'h0, i[1:0], i[2], 6'h02}, r);
            repeat (3) @(posedge mclk);
            chk(user_clock_ratio, ratio_tab[i]);
            chk(width_error, ratio_tab[i] == 2'h3);
        end
    endtask
    task automatic t_polarity;
        logic [1:0] r;
        for (int p = 0; p < 8; p++)
        begin
            wr(8'h00, {28'h008, p[2], 3'h2}, r);
            @(posedge mclk);
            tx_serial_bit <= p[0];
            tx_polarity_invert <= p[1];
            repeat (2) @(posedge mclk);
            #1;
            chk(serial_out_pos, p[0] ^ p[1] ^ p[2]);
        end
        @(posedge mclk);
        tx_polarity_invert <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(serial_out_pos, 1'b0);
    endtask
    task automatic t_lock;
        int         n;
        logic [1:0] r;
        @(posedge mclk);
        send_en <= 1'b1;
        wait_lock(1'b1, n);
        chk(n > LOCK_EDGES, 1'b1);
        rx_lock_source_select <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(rx_on_reference, 1'b1);
        rx_lock_source_select <= 1'b0;
        wait_lock(1'b1, n);
        wr(8'h00, 32'h0a2, r);
        repeat (3) @(posedge mclk);
        chk(rx_on_reference, 1'b1);
        wr(8'h00, 32'h082, r);
        wait_lock(1'b1, n);
        // Sparse transitions with short gaps must not drop lock.
        repeat (10)
        begin
            send_en <= 1'b0;
            repeat (6) @(posedge mclk);
            send_en <= 1'b1;
            repeat (2) @(posedge mclk);
        end
        chk(rx_locked, 1'b1);
        send_en <= 1'b0;
        wait_lock(1'b0, n);
        chk(n >= 2 * MISS_LIMIT, 1'b1);
        repeat (10) @(posedge mclk);
        chk(rx_data_bit, serial_in_pos);
        wr(8'h00, 32'h092, r);
        repeat (10) @(posedge mclk);
        chk(rx_data_bit, serial_in_neg);
        wr(8'h00, 32'h082, r);
    endtask
    task automatic t_fifo;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge mclk);
            tx_wr <= 1'b1;
            tx_din <= 16'h1000 + 16'(i);
        end
        @(posedge mclk);
        tx_wr <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge mclk);
            tx_rd <= 1'b1;
            @(posedge mclk);
            tx_rd <= 1'b0;
            #1;
            chk(tx_dout_valid, i < 4);
            if (i < 4) chk(tx_dout, 16'h1000 + 16'(i));
        end
        rd(8'h10, d, r);
        chk(d[13:12], 2'h3);
        wr(8'h10, 32'h30, r);
        rd(8'h10, d, r);
        chk(d[13:12], 2'h0);
    endtask
    task automatic t_settings;
        logic [31:0] d;
        logic [1:0]  r;
        wr(8'h04, 32'h5, r);
        wr(8'h08, 32'hf, r);
        wr(8'h0c, 32'h3, r);
        chk(swing_level, 4'h5);
        chk(emphasis_level, 4'ha);
        chk(rx_equalization_level, 3'h3);
        rd(8'h14, d, r);
        chk({d, r}, 34'h2);
        wr(8'h20, 32'h1, r);
        chk(r, 2'h2);
    endtask

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, bit_tick} = 6'h0;
        {tx_serial_bit, tx_polarity_invert, rx_lock_source_select} = 3'h0;
        {tx_wr, tx_rd, send_en, awaddr, araddr, wdata, tx_din} = 67'h0;
        {checks, miscompares, cycles} = 0;
        srst = 1'b1;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        t_reset;
        t_modes;
        t_widths;
        t_polarity;
        t_lock;
        t_fifo;
        t_settings;
        end_of_test;
    end
endmodule // lane_ctrl_bench

bind lane_ctrl lane_ctrl_asserts i_lane_ctrl_asserts (.*);
